// >>> ftb_checker.sv
// Purpose: concurrent checks on the totalizer, batch and setpoint ports
// Assumes: SPW matches the bound design, one clock domain
// Notes: sees only top-level ports, attached with bind below
`timescale 1ns/100ps
module ftb_checker #(
   parameter SPW = 16
) (
   input wire mclk_i,
   input wire arst_n_i,
   input wire tot_reset_i,
   input wire src_analog_i,
   input wire serial_sp_wr_i,
   input wire [SPW-1:0] serial_sp_i,
   input wire [SPW-1:0] full_scale_i,
   input wire [15:0] lim_lo_frac_i,
   input wire [15:0] lim_hi_frac_i,
   input wire pu_fixed_i,
   input wire [23:0] total_o,
   input wire missed_flow_error_o,
   input wire total_flash_o,
   input wire [13:0] hours_o,
   input wire [5:0] minutes_o,
   input wire [5:0] seconds_o,
   input wire [SPW-1:0] setpoint_o,
   input wire [SPW-1:0] flow_sp_o,
   input wire valve_close_o,
   input wire batch_done_o,
   input wire [23:0] batch_size_o,
   input wire serial_err_o,
   input wire panel_block_o,
   input wire nv_sp_wr_o
);
   // Limits in flow units; full-scale fractions are x/65536
   wire [31:0] lo = (full_scale_i * lim_lo_frac_i) >> 16;
   wire [31:0] hi = (full_scale_i * lim_hi_frac_i) >> 16;
   wire take = serial_sp_wr_i && !src_analog_i;
   wire in_rng = serial_sp_i >= lo && serial_sp_i <= hi;

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   // Everything cleared, timer included, in one step
   sequence clear_s;
      total_o == 24'h000000 && !missed_flow_error_o
      ##0 hours_o == 14'h0000 && minutes_o == 6'h00 && seconds_o == 6'h00;
   endsequence
   // Accepted value lands and is remembered
   sequence take_s;
      setpoint_o == $past(serial_sp_i) ##0 nv_sp_wr_o;
   endsequence

   panel_block_a: assert property (panel_block_o == src_analog_i)
      else $error("panel entry not blocked in analog mode");
   total_flash_a: assert property (total_flash_o == missed_flow_error_o)
      else $error("total flash differs from missed flow error");
   valve_close_a: assert property (valve_close_o ==
      (batch_size_o != 24'h000000 && total_o >= batch_size_o))
      else $error("valve close does not match batch and total");
   batch_done_a: assert property ($rose(valve_close_o) |=> batch_done_o)
      else $error("batch completion not flagged");
   valve_zero_a: assert property (valve_close_o |-> flow_sp_o == 0)
      else $error("flow setpoint nonzero with valve closed");
   sp_take_a: assert property (take && in_rng && !pu_fixed_i |=> take_s)
      else $error("in-range serial setpoint not applied");
   sp_refuse_a: assert property (take && !in_rng |=>
      serial_err_o && $stable(setpoint_o))
      else $error("out-of-range serial setpoint not refused");
   analog_ignore_a: assert property (
      src_analog_i && serial_sp_wr_i |=> !serial_err_o)
      else $error("serial setpoint handled in analog mode");
   tot_clear_a: assert property (tot_reset_i |=> clear_s)
      else $error("totalizer reset did not clear");
endmodule

bind ftb_top ftb_checker #(.SPW(SPW)) i_ftb_checker (.*);

// >>> ftb_host.sv
// Purpose: far-side model: fieldbus master and analog setpoint knob
// Assumes: talk_i low means the fieldbus master has gone silent
// Notes: knob output lags its setting by one clock like a sampled input
`timescale 1ns/100ps
module ftb_host (
   input wire mclk_i,
   input wire arst_n_i,
   input wire talk_i,
   input wire [15:0] knob_set_i,
   output reg bus_activity_o,
   output reg [15:0] knob_o
);
   reg [2:0] gap_ff;

   // Poll every eighth clock while alive, nothing once silent
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gap_ff <= 3'h0;
         bus_activity_o <= 1'b0;
         knob_o <= 16'h0000;
      end else begin
         gap_ff <= gap_ff + 3'h1;
         bus_activity_o <= talk_i && gap_ff == 3'h7;
         knob_o <= knob_set_i;
      end
   end
endmodule

// >>> ftb_regs.vh
// Purpose: constants for the flow totalizer, batch and setpoint block
// Assumes: 50 MHz system clock, 1000 measurement samples per second
// Notes: all counts are derived here so every file shares one value
`ifndef FTB_REGS_VH
`define FTB_REGS_VH
`define FTB_CLK_HZ 50000000
`define FTB_SAMPLE_HZ 1000
`define FTB_SAMPLE_DIV (`FTB_CLK_HZ / `FTB_SAMPLE_HZ)
`define FTB_TOT_MAX 24'h98967f
`define FTB_HOURS_MAX 14'h270f
`define FTB_MINSEC_MAX 6'h3b
`define FTB_FRAC_SHIFT 16
`endif

// >>> ftb_secwait.v
// Purpose: seconds counter that reports when a limit has been reached
// Assumes: sec_i is a one-cycle pulse per second
// Notes: a limit of zero means never, which gives an infinite wait
`timescale 1ns/100ps
module ftb_secwait #(
   parameter W = 16
) (
   input wire mclk_i,
   input wire arst_n_i,
   input wire run_i,
   input wire clr_i,
   input wire sec_i,
   input wire [W-1:0] lim_i,
   output wire hit_o
);
   reg [W-1:0] cnt_ff;

   // Saturating count so a long wait never wraps back below the limit
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_ff <= {W{1'b0}};
      end else if (clr_i || !run_i) begin
         cnt_ff <= {W{1'b0}};
      end else if (sec_i && (cnt_ff != {W{1'b1}})) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   assign hit_o = run_i && (lim_i != {W{1'b0}}) && (cnt_ff >= lim_i);
endmodule

// >>> ftb_tick.v
// Purpose: counts increments and pulses once every DIV of them
// Assumes: inc_i and clr_i come from logic on mclk_i
// Notes: clr_i restarts the count so a phase can be realigned
`timescale 1ns/100ps
module ftb_tick #(
   parameter W = 16,
   parameter DIV = 50000
) (
   input wire mclk_i,
   input wire arst_n_i,
   input wire clr_i,
   input wire inc_i,
   output reg tick_o
);
   // Terminal count cut to the counter width on purpose
   localparam integer LAST_I = DIV - 1;
   localparam [W-1:0] LAST = LAST_I[W-1:0];
   reg [W-1:0] cnt_ff;

   // Count and emit a one-cycle pulse at the wrap
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_ff <= {W{1'b0}};
         tick_o <= 1'b0;
      end else if (clr_i) begin
         cnt_ff <= {W{1'b0}};
         tick_o <= 1'b0;
      end else begin
         tick_o <= inc_i && (cnt_ff == LAST);
         if (inc_i) begin
            cnt_ff <= (cnt_ff == LAST) ? {W{1'b0}} : cnt_ff + 1'b1;
         end
      end
   end
endmodule

// >>> ftb_top.v
// Purpose: flow totalizer, elapsed timer, batch control, setpoint handling
// Assumes: all inputs come from logic on mclk_i, none from raw pins
// Notes: ramp generation, control loop and display are outside this block
`timescale 1ns/100ps
`include "ftb_regs.vh"
module ftb_top #(
   parameter SAMPLE_DIV = `FTB_SAMPLE_DIV,
   parameter TOT_DIV = `FTB_SAMPLE_HZ,
   parameter SPW = 16
) (
   input wire mclk_i,
   input wire arst_n_i,
   input wire [15:0] flow_i,
   input wire [15:0] flow_ceiling_i,
   input wire freeze_mode_i,
   input wire tot_reset_i,
   input wire batch_wr_i,
   input wire [23:0] batch_val_i,
   input wire [23:0] nv_batch_i,
   input wire src_analog_i,
   input wire serial_sp_wr_i,
   input wire [SPW-1:0] serial_sp_i,
   input wire panel_sp_wr_i,
   input wire [SPW-1:0] panel_sp_i,
   input wire [SPW-1:0] setpoint_knob_i,
   input wire [SPW-1:0] full_scale_i,
   input wire [15:0] lim_lo_frac_i,
   input wire [15:0] lim_hi_frac_i,
   input wire bus_activity_i,
   input wire [15:0] bus_timeout_s_i,
   input wire bus_timeout_zero_i,
   input wire pu_fixed_i,
   input wire [SPW-1:0] pu_fixed_sp_i,
   input wire [SPW-1:0] nv_sp_i,
   input wire ramp_jump_i,
   input wire autotare_en_i,
   input wire [15:0] tare_delay_s_i,
   output reg [23:0] total_o,
   output reg total_overflow_indication_o,
   output reg missed_flow_error_o,
   output wire total_flash_o,
   output reg [13:0] hours_o,
   output reg [5:0] minutes_o,
   output reg [5:0] seconds_o,
   output reg [SPW-1:0] setpoint_o,
   output wire [SPW-1:0] flow_sp_o,
   output wire valve_close_o,
   output reg batch_done_o,
   output wire batch_active_o,
   output reg [23:0] batch_size_o,
   output reg [23:0] remaining_o,
   output reg serial_err_o,
   output reg panel_err_o,
   output wire panel_block_o,
   output reg tare_req_o,
   output reg nv_sp_wr_o,
   output reg nv_batch_wr_o,
   output reg ramp_from_zero_o,
   output wire ramp_honor_o
);
   wire sample_tick;
   wire sec_tick;
   wire tare_hit;
   wire tmo_hit;
   reg init_done_ff;
   reg [15:0] frac_ff;
   reg tare_hit_ff;
   reg tmo_hit_ff;
   reg [15:0] flow_clip;
   reg clipped;
   reg [16:0] sum;
   reg [16:0] inc;
   reg [24:0] tot_add;
   reg [23:0] nxt_total;
   reg nxt_ovf_evt;
   reg [SPW-1:0] lim_lo;
   reg [SPW-1:0] lim_hi;
   reg [SPW-1:0] knob_clamped;
   reg [31:0] prod_lo;
   reg [31:0] prod_hi;
   reg serial_ok;
   reg panel_ok;
   reg timer_max;

   // 1 kHz measurement strobe, from which the whole block keeps time
   ftb_tick #(.W(16), .DIV(SAMPLE_DIV)) u_sample (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .clr_i(1'b0),
      .inc_i(1'b1),
      .tick_o(sample_tick)
   );

   // Seconds from samples; restarted by totalizer reset so timer starts clean
   ftb_tick #(.W(10), .DIV(`FTB_SAMPLE_HZ)) u_sec (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .clr_i(tot_reset_i),
      .inc_i(sample_tick),
      .tick_o(sec_tick)
   );

   // Zero-setpoint dwell before an automatic tare
   ftb_secwait #(.W(16)) u_tare (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .run_i(autotare_en_i && (setpoint_o == {SPW{1'b0}})),
      .clr_i(1'b0),
      .sec_i(sec_tick),
      .lim_i(tare_delay_s_i),
      .hit_o(tare_hit)
   );

   // Idle fieldbus watchdog; any activity restarts it
   ftb_secwait #(.W(16)) u_tmo (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .run_i(1'b1),
      .clr_i(bus_activity_i),
      .sec_i(sec_tick),
      .lim_i(bus_timeout_s_i),
      .hit_o(tmo_hit)
   );

   // Batch gating: flow setpoint forced to zero once the total reaches a nonzero batch size
   assign batch_active_o = (batch_size_o != 24'h000000);
   assign valve_close_o = batch_active_o &&
                          (total_o >= batch_size_o);
   assign flow_sp_o = valve_close_o ? {SPW{1'b0}} : setpoint_o;
   assign total_flash_o = missed_flow_error_o;
   assign panel_block_o = src_analog_i;
   assign ramp_honor_o = ~ramp_jump_i;

   // Limits scale with full scale, so a variable change keeps percentages
   always @* begin
      prod_lo = full_scale_i * lim_lo_frac_i;
      prod_hi = full_scale_i * lim_hi_frac_i;
      lim_lo = prod_lo[`FTB_FRAC_SHIFT +: SPW];
      lim_hi = prod_hi[`FTB_FRAC_SHIFT +: SPW];
      if (setpoint_knob_i < lim_lo) begin
         knob_clamped = lim_lo;
      end else if (setpoint_knob_i > lim_hi) begin
         knob_clamped = lim_hi;
      end else begin
         knob_clamped = setpoint_knob_i;
      end
      serial_ok = (serial_sp_i >= lim_lo) && (serial_sp_i <= lim_hi);
      panel_ok = (panel_sp_i >= lim_lo) && (panel_sp_i <= lim_hi);
   end

   // Accumulation step: ceiling clip, then rate times sample period
   always @* begin
      clipped = (flow_i > flow_ceiling_i);
      flow_clip = clipped ? flow_ceiling_i : flow_i;
      sum = {1'b0, frac_ff} + {1'b0, flow_clip};
      inc = sum / TOT_DIV[16:0];
      tot_add = {1'b0, total_o} + {8'h00, inc};
      nxt_ovf_evt = (tot_add > {1'b0, `FTB_TOT_MAX});
      if (!nxt_ovf_evt) begin
         nxt_total = tot_add[23:0];
      end else if (freeze_mode_i) begin
         nxt_total = `FTB_TOT_MAX;
      end else begin
         nxt_total = 24'h000000;
      end
   end

   // Totalizer: counts on every sample tick unless frozen at max, whether or not the valve is closed
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         total_o <= 24'h000000;
         frac_ff <= 16'h0000;
         total_overflow_indication_o <= 1'b0;
         missed_flow_error_o <= 1'b0;
      end else if (tot_reset_i) begin
         total_o <= 24'h000000;
         frac_ff <= 16'h0000;
         total_overflow_indication_o <= 1'b0;
         missed_flow_error_o <= 1'b0;
      end else if (sample_tick) begin
         // Freeze at max stops counting; flow is still measured
         if (!(freeze_mode_i && total_overflow_indication_o)) begin
            total_o <= nxt_total;
            frac_ff <= sum[15:0] - inc[15:0] * TOT_DIV[15:0];
         end
         if (nxt_ovf_evt) begin
            total_overflow_indication_o <= 1'b1;
         end
         if (clipped) begin
            missed_flow_error_o <= 1'b1;
         end
      end
   end

   // Elapsed timer, stopped by batch completion and pinned at its maximum
   always @* begin
      timer_max = (hours_o == `FTB_HOURS_MAX) &&
                  (minutes_o == `FTB_MINSEC_MAX) &&
                  (seconds_o == `FTB_MINSEC_MAX);
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hours_o <= 14'h0000;
         minutes_o <= 6'h00;
         seconds_o <= 6'h00;
      end else if (tot_reset_i) begin
         hours_o <= 14'h0000;
         minutes_o <= 6'h00;
         seconds_o <= 6'h00;
      end else if (sec_tick && !valve_close_o && !timer_max) begin
         if (seconds_o != `FTB_MINSEC_MAX) begin
            seconds_o <= seconds_o + 6'h01;
         end else begin
            seconds_o <= 6'h00;
            if (minutes_o != `FTB_MINSEC_MAX) begin
               minutes_o <= minutes_o + 6'h01;
            end else begin
               minutes_o <= 6'h00;
               hours_o <= hours_o + 14'h0001;
            end
         end
      end
   end

   // Batch status; remaining shows zero once the batch is met
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         batch_done_o <= 1'b0;
         remaining_o <= 24'h000000;
      end else begin
         batch_done_o <= valve_close_o;
         if (batch_active_o && !valve_close_o) begin
            remaining_o <= batch_size_o - total_o;
         end else begin
            remaining_o <= 24'h000000;
         end
      end
   end

   // Batch size: restored from storage once after reset, saved on change
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         batch_size_o <= 24'h000000;
         nv_batch_wr_o <= 1'b0;
      end else if (!init_done_ff) begin
         batch_size_o <= nv_batch_i;
         nv_batch_wr_o <= 1'b0;
      end else begin
         nv_batch_wr_o <= batch_wr_i;
         if (batch_wr_i) begin
            batch_size_o <= batch_val_i;
         end
      end
   end

   // Setpoint: power-up load, then source arbitration and timeout override
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         init_done_ff <= 1'b0;
         setpoint_o <= {SPW{1'b0}};
         serial_err_o <= 1'b0;
         panel_err_o <= 1'b0;
         nv_sp_wr_o <= 1'b0;
         tmo_hit_ff <= 1'b0;
      end else begin
         init_done_ff <= 1'b1;
         tmo_hit_ff <= tmo_hit;
         serial_err_o <= 1'b0;
         panel_err_o <= 1'b0;
         nv_sp_wr_o <= 1'b0;
         if (!init_done_ff) begin
            setpoint_o <= pu_fixed_i ? pu_fixed_sp_i : nv_sp_i;
         end else if (tmo_hit && !tmo_hit_ff && bus_timeout_zero_i) begin
            setpoint_o <= {SPW{1'b0}};
         end else if (src_analog_i) begin
            setpoint_o <= knob_clamped;
         end else if (serial_sp_wr_i) begin
            // Same-cycle clash goes to serial; otherwise latest wins
            if (serial_ok) begin
               setpoint_o <= serial_sp_i;
               nv_sp_wr_o <= ~pu_fixed_i;
            end else begin
               serial_err_o <= 1'b1;
            end
         end else if (panel_sp_wr_i) begin
            if (panel_ok) begin
               setpoint_o <= panel_sp_i;
               nv_sp_wr_o <= ~pu_fixed_i;
            end else begin
               panel_err_o <= 1'b1;
            end
         end
      end
   end

   // Tare request on the first second the dwell is met, once per zero spell
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tare_hit_ff <= 1'b0;
         tare_req_o <= 1'b0;
      end else begin
         tare_hit_ff <= tare_hit;
         tare_req_o <= tare_hit && !tare_hit_ff;
      end
   end

   // Ramp reference begins at zero after power-up until the first setpoint
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ramp_from_zero_o <= 1'b1;
      end else if (init_done_ff) begin
         ramp_from_zero_o <= 1'b0;
      end
   end
endmodule

// >>> ftb_top_test.sv
// Purpose: self-checking bench for the flow totalizer block
// Assumes: SAMPLE_DIV cut to 40, so one second lasts 40000 clocks
// Notes: results are noted in a queue and compared when they appear
`timescale 1ns/100ps
module ftb_top_test;
   reg mclk_i = 1'b0, arst_n_i = 1'b0, tot_reset_i = 1'b0;
   reg batch_wr_i = 1'b0, src_analog_i = 1'b0, talk_r = 1'b1;
   reg serial_sp_wr_i = 1'b0, panel_sp_wr_i = 1'b0;
   reg bus_timeout_zero_i = 1'b1, ramp_jump_i = 1'b0;
   reg [15:0] flow_i = 16'h0000, flow_ceiling_i = 16'h07d0;
   reg [15:0] serial_sp_i = 16'h0000, panel_sp_i = 16'h0000;
   reg [15:0] knob_r = 16'h0000, full_scale_i = 16'h03e8;
   reg [15:0] lim_lo_frac_i = 16'h2000, lim_hi_frac_i = 16'hc000;
   reg [15:0] bus_timeout_s_i = 16'h0000, tare_delay_s_i = 16'h0001;
   reg [15:0] nv_sp_i = 16'h00c8, last = 16'h00c8;
   reg [23:0] batch_val_i = 24'h000000, nv_batch_i = 24'h000010;
   reg [24:0] e;
   reg [24:0] q[$];
   wire bus_activity_i, missed_flow_error_o, valve_close_o, batch_done_o;
   wire serial_err_o, panel_err_o, tare_req_o;
   wire nv_sp_wr_o, nv_batch_wr_o, ramp_from_zero_o;
   wire ramp_honor_o, batch_active_o;
   wire [15:0] setpoint_knob_i, setpoint_o, flow_sp_o;
   wire [23:0] total_o, batch_size_o, remaining_o;
   wire [5:0] seconds_o;
   wire [31:0] lo = (full_scale_i * lim_lo_frac_i) >> 16;
   wire [31:0] hi = (full_scale_i * lim_hi_frac_i) >> 16;
   integer err_count = 0, n_checks = 0, cyc = 0, k, seed = 32'h8954;

   ftb_top #(.SAMPLE_DIV(40)) i_ftb_top (
      .*,
      .freeze_mode_i(1'b0),
      .pu_fixed_i(1'b0),
      .pu_fixed_sp_i(16'h0000),
      .autotare_en_i(1'b1),
      .total_overflow_indication_o(),
      .total_flash_o(),
      .hours_o(),
      .minutes_o(),
      .panel_block_o()
   );
   ftb_host i_ftb_host (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .talk_i(talk_r),
      .knob_set_i(knob_r),
      .bus_activity_o(bus_activity_i),
      .knob_o(setpoint_knob_i)
   );

   // 50 MHz clock
   always #10 mclk_i = ~mclk_i;

   // Cut a hang short; the run needs about 81000 clocks
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         err_count = err_count + 1;
         results;
      end
   end

   // Compare the oldest note whenever a write is answered
   always @(negedge mclk_i) begin
      if ((nv_sp_wr_o | serial_err_o | panel_err_o | nv_batch_wr_o) === 1'b1
          && q.size() > 0) begin
         e = q.pop_front();
         if (e[24])
            chk("batch", batch_size_o, e[23:0]);
         else
            chk("setpt", {8'h00, setpoint_o}, e[23:0]);
      end
   end

   task chk(input [47:0] nm, input [23:0] seen, input [23:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("wrong value %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask

   // One setpoint write; an edge with the strobe low follows it
   task sp(input pan, input [15:0] v);
      begin
         if (pan)
            panel_sp_i <= v;
         else
            serial_sp_i <= v;
         panel_sp_wr_i <= pan;
         serial_sp_wr_i <= !pan;
         if (!src_analog_i && v >= lo && v <= hi)
            last = v;
         if (!src_analog_i)
            q.push_back({9'h000, last});
         @(posedge mclk_i);
         panel_sp_wr_i <= 1'b0;
         serial_sp_wr_i <= 1'b0;
         @(posedge mclk_i);
      end
   endtask

   task bat(input [23:0] v);
      begin
         batch_val_i <= v;
         batch_wr_i <= 1'b1;
         q.push_back({1'b1, v});
         @(posedge mclk_i);
         batch_wr_i <= 1'b0;
         @(posedge mclk_i);
      end
   endtask

   task results;
      begin
         if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   // Main sequence
   initial begin
      repeat (2) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      @(posedge mclk_i);
      @(negedge mclk_i);
      chk("setpt", {8'h00, setpoint_o}, 24'h0000c8);
      chk("batch", batch_size_o, 24'h000010);
      chk("rampz", {23'h0, ramp_from_zero_o}, 24'h000001);
      chk("ramph", {23'h0, ramp_honor_o}, 24'h000001);
      @(posedge mclk_i);
      for (k = 0; k < 12; k = k + 1)
         sp(k[0], {$random(seed)} % 1000);
      sp(1'b0, 16'h007c);
      sp(1'b1, 16'h02ee);
      // Analog source: other inputs ignored, knob clamped to the limits
      src_analog_i <= 1'b1;
      knob_r <= 16'h03e8;
      @(posedge mclk_i);
      sp(1'b0, 16'h012c);
      sp(1'b1, 16'h0190);
      @(negedge mclk_i);
      chk("setpt", {8'h00, setpoint_o}, hi[23:0]);
      @(posedge mclk_i);
      knob_r <= 16'h0010;
      repeat (4) @(posedge mclk_i);
      @(negedge mclk_i);
      chk("setpt", {8'h00, setpoint_o}, lo[23:0]);
      @(posedge mclk_i);
      src_analog_i <= 1'b0;
      ramp_jump_i <= 1'b1;
      @(posedge mclk_i);
      sp(1'b0, 16'h01f4);
      // Batch of 16 from a fresh total, then resize and remove it
      tot_reset_i <= 1'b1;
      @(posedge mclk_i);
      tot_reset_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      @(negedge mclk_i);
      chk("remain", remaining_o, 24'h000010);
      @(posedge mclk_i);
      flow_i <= 16'h03e8;
      for (k = 0; k < 2000 && valve_close_o !== 1'b1; k = k + 1)
         @(negedge mclk_i);
      chk("total", total_o, 24'h000010);
      chk("flowsp", {8'h00, flow_sp_o}, 24'h000000);
      @(posedge mclk_i);
      bat(24'h000008);
      @(negedge mclk_i);
      chk("valve", {23'h0, valve_close_o}, 24'h000001);
      @(posedge mclk_i);
      bat(24'h000028);
      @(negedge mclk_i);
      chk("valve", {23'h0, valve_close_o}, 24'h000000);
      @(posedge mclk_i);
      bat(24'h000000);
      @(negedge mclk_i);
      chk("flowsp", {8'h00, flow_sp_o}, 24'h0001f4);
      chk("bact", {23'h0, batch_active_o}, 24'h000000);
      chk("ramph", {23'h0, ramp_honor_o}, 24'h000000);
      // Flow above the ceiling
      @(posedge mclk_i);
      flow_i <= 16'h0bb8;
      repeat (90) @(posedge mclk_i);
      @(negedge mclk_i);
      chk("missed", {23'h0, missed_flow_error_o}, 24'h000001);
      // Silent fieldbus with a one-second timeout, then autotare
      @(posedge mclk_i);
      tot_reset_i <= 1'b1;
      talk_r <= 1'b0;
      flow_i <= 16'h0000;
      bus_timeout_s_i <= 16'h0001;
      @(posedge mclk_i);
      tot_reset_i <= 1'b0;
      for (k = 0; k < 45000 && setpoint_o !== 16'h0000; k = k + 1)
         @(negedge mclk_i);
      chk("setpt", {8'h00, setpoint_o}, 24'h000000);
      chk("secs", {18'h0, seconds_o}, 24'h000001);
      chk("missed", {23'h0, missed_flow_error_o}, 24'h000000);
      for (k = 0; k < 45000 && tare_req_o !== 1'b1; k = k + 1)
         @(negedge mclk_i);
      chk("tare", {23'h0, tare_req_o}, 24'h000001);
      results;
   end
endmodule
